// [hdl/exp_mem_if.sv]
// Carrier between the register bank and the expanded storage
`default_nettype none
interface exp_mem_if;
	logic wr_en;
	logic [mgmt_regs_pkg::EXP_INDEX_BITS-1:0] addr;
	logic [7:0] wr_data;
	logic [7:0] rd_data;
	modport bank (output wr_en, output addr, output wr_data, input rd_data);
	modport mem (input wr_en, input addr, input wr_data, output rd_data);
endinterface
`default_nettype wire

// [hdl/expanded_store.sv]
// Expanded address space storage, flip-flops indexed by the pointer
`default_nettype none
module expanded_store (
	input wire logic core_clk_in, // System clock
	input wire logic rstn_in, // Synchronous reset, active low
	exp_mem_if.mem port_if // Access from the register bank
);
	logic [7:0] cells [mgmt_regs_pkg::EXP_DEPTH];

	// Cells clear on reset so reads are defined
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			for (int i = 0; i < mgmt_regs_pkg::EXP_DEPTH; i++) begin
				cells[i] <= 8'h00;
			end
		end else if (port_if.wr_en) begin
			cells[port_if.addr] <= port_if.wr_data;
		end
	end

	// Combinational read; the bank registers the result
	assign port_if.rd_data = cells[port_if.addr];
endmodule // expanded_store
`default_nettype wire

// [hdl/mgmt_regs_pkg.sv]
// Constants shared by the management register bank and its expanded window
`default_nettype none
package mgmt_regs_pkg;
	// Register offsets on the management port (5-bit register address)
	localparam logic [4:0] REG_BASIC_CONTROL = 5'h00;
	localparam logic [4:0] REG_AUTONEG_ADVERTISEMENT = 5'h04;
	localparam logic [4:0] REG_NEXT_PAGE_TRANSMIT = 5'h07;
	localparam logic [4:0] REG_NEXT_PAGE_RECEIVE = 5'h08;
	localparam logic [4:0] REG_EXPANDED_ACCESS_ENABLE = 5'h16;
	localparam logic [4:0] REG_EXPANDED_DATA_WINDOW = 5'h1D;
	localparam logic [4:0] REG_EXPANDED_ADDRESS_POINTER = 5'h1E;
	// Field positions
	localparam int BC_RESTART_AN_BIT = 9;
	localparam int BC_ISOLATE_BIT = 10;
	localparam int BC_POWER_DOWN_BIT = 11;
	localparam int BC_AN_ENABLE_BIT = 12;
	localparam int BC_SOFT_RESET_BIT = 15;
	localparam int ADV_ASYM_PAUSE_BIT = 11;
	localparam int NEXT_PAGE_FOLLOWS_FLAG_BIT = 15;
	// Values
	localparam logic [15:0] BASIC_CONTROL_RESET = 16'h1000;
	localparam logic [15:0] ADVERTISEMENT_RESET = 16'h01E1;
	localparam logic [15:0] EXPANDED_ENABLE_KEY = 16'h000D;
	localparam logic [15:0] EXP_ADDR_ASYM_PAUSE = 16'h8084;
	localparam logic [15:0] EXP_ADDR_NP_NOTICE = 16'h80DD;
	localparam logic [15:0] EXP_NP_NOTICE_VALUE = 16'h0040;
	// Expanded storage: 8-bit locations indexed by the low pointer bits
	localparam int EXP_INDEX_BITS = 8;
	localparam int EXP_DEPTH = 256;
	// Isolate release times and derived cycle counts at 100 MHz
	localparam int CLK_PERIOD_NS = 10;
	localparam int ISOLATE_CLEAR_US = 100;
	localparam int RESET_RELEASE_US = 500;
	localparam int ISOLATE_CLEAR_CYCLES = (ISOLATE_CLEAR_US * 1000) / CLK_PERIOD_NS;
	localparam int RESET_RELEASE_CYCLES = (RESET_RELEASE_US * 1000) / CLK_PERIOD_NS;
	localparam int TIMER_BITS = 16;
	// Negotiation states
	typedef enum logic [3:0] {
		NEG_IDLE = 4'b0001,
		NEG_SEND = 4'b0010,
		NEG_WAIT = 4'b0100,
		NEG_DONE = 4'b1000
	} neg_state_e;
endpackage
`default_nettype wire

// [hdl/phy_expanded_access_next_page.sv]
// Management register bank with expanded window and next-page handling
// Operation
// - Isolate clear reaches normal within 100 us
// - Reset release reaches normal within 500 us
// - Asymmetric pause advertisement bit read-only zero
// - Key 0x0D at 0x16 opens window
// - Register 0x1E points into expanded space
// - Data register reads/writes pointed location
// - Pointer increments after each data access
// - Device ends exchange after own final page
// - Equal or fewer partner pages completes normally
// - Notice write at 0x80DD flags loaded page
// - Writing zero clears next-page receive register
// - Bits 12 and 9 enable and restart
`default_nettype none
module phy_expanded_access_next_page (
	input wire logic core_clk_in, // System clock, 100 MHz
	input wire logic rstn_in, // Synchronous reset, active low
	input wire logic reg_wr_in, // Management write strobe, one cycle
	input wire logic reg_rd_in, // Management read strobe, one cycle
	input wire logic [4:0] reg_addr_in, // Register address
	input wire logic [15:0] reg_wdata_in, // Write data
	input wire logic page_rx_valid_in, // Partner page received, one cycle
	input wire logic [15:0] page_rx_data_in, // Partner page word
	output logic [15:0] reg_rdata_out, // Read data, valid cycle after strobe
	output logic isolate_out, // Device held in isolate mode
	output logic page_tx_valid_out, // Own page sent, one cycle
	output logic [15:0] page_tx_data_out, // Own page word
	output logic neg_complete_out, // Negotiation completed
	output logic neg_failed_out, // Exchange ended early, no link
	output logic asym_pause_adv_out // Asymmetric pause advertised
);
	logic [15:0] basic_control;
	logic [15:0] advertisement;
	logic [15:0] next_page_transmit;
	logic [15:0] next_page_receive;
	logic [15:0] expanded_access_enable;
	logic [15:0] expanded_address_pointer;
	logic asym_pause_cfg;
	logic np_loaded;
	logic [mgmt_regs_pkg::TIMER_BITS-1:0] iso_timer;
	mgmt_regs_pkg::neg_state_e neg_state;
	logic window_open;
	logic data_access;
	logic data_write;
	logic restart_req;
	logic [15:0] next_rdata;
	exp_mem_if mem_if ();

	expanded_store u_store (
		.core_clk_in(core_clk_in),
		.rstn_in(rstn_in),
		.port_if(mem_if)
	);

	// Register write decode shared by several processes
	function automatic logic hit(input logic [4:0] a, input logic [4:0] r);
		return a == r;
	endfunction

	// Window opens only on the exact key value
	assign window_open = (expanded_access_enable == mgmt_regs_pkg::EXPANDED_ENABLE_KEY);
	assign data_access = window_open && (reg_wr_in || reg_rd_in)
		&& hit(reg_addr_in, mgmt_regs_pkg::REG_EXPANDED_DATA_WINDOW);
	assign data_write = data_access && reg_wr_in;
	assign restart_req = reg_wr_in && hit(reg_addr_in, mgmt_regs_pkg::REG_BASIC_CONTROL)
		&& reg_wdata_in[mgmt_regs_pkg::BC_AN_ENABLE_BIT]
		&& reg_wdata_in[mgmt_regs_pkg::BC_RESTART_AN_BIT];

	// Storage addressed by the pointer as it stands before the increment
	assign mem_if.addr = expanded_address_pointer[mgmt_regs_pkg::EXP_INDEX_BITS-1:0];
	assign mem_if.wr_en = data_write;
	assign mem_if.wr_data = reg_wdata_in[7:0];

	// Basic control; restart bit self-clears, soft reset returns defaults
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			basic_control <= mgmt_regs_pkg::BASIC_CONTROL_RESET;
		end else if (reg_wr_in && hit(reg_addr_in, mgmt_regs_pkg::REG_BASIC_CONTROL)) begin
			if (reg_wdata_in[mgmt_regs_pkg::BC_SOFT_RESET_BIT]) begin
				basic_control <= mgmt_regs_pkg::BASIC_CONTROL_RESET;
			end else begin
				basic_control <= reg_wdata_in;
				basic_control[mgmt_regs_pkg::BC_RESTART_AN_BIT] <= 1'b0;
			end
		end
	end

	// Advertisement; the pause bit is never taken from a direct write
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			advertisement <= mgmt_regs_pkg::ADVERTISEMENT_RESET;
		end else if (reg_wr_in && hit(reg_addr_in, mgmt_regs_pkg::REG_AUTONEG_ADVERTISEMENT)) begin
			advertisement <= reg_wdata_in;
			advertisement[mgmt_regs_pkg::ADV_ASYM_PAUSE_BIT] <= 1'b0;
		end
	end

	// Transmit page word and access key
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			next_page_transmit <= 16'h0000;
			expanded_access_enable <= 16'h0000;
		end else if (reg_wr_in) begin
			if (hit(reg_addr_in, mgmt_regs_pkg::REG_NEXT_PAGE_TRANSMIT)) begin
				next_page_transmit <= reg_wdata_in;
			end
			if (hit(reg_addr_in, mgmt_regs_pkg::REG_EXPANDED_ACCESS_ENABLE)) begin
				expanded_access_enable <= reg_wdata_in;
			end
		end
	end

	// Pointer: a direct load wins, otherwise advance after each data access
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			expanded_address_pointer <= 16'h0000;
		end else if (reg_wr_in && hit(reg_addr_in, mgmt_regs_pkg::REG_EXPANDED_ADDRESS_POINTER)) begin
			expanded_address_pointer <= reg_wdata_in;
		end else if (data_access) begin
			expanded_address_pointer <= expanded_address_pointer + 16'h0001;
		end
	end

	// Special expanded locations that steer the block's own behaviour
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			asym_pause_cfg <= 1'b0;
			np_loaded <= 1'b0;
		end else begin
			if (data_write && expanded_address_pointer == mgmt_regs_pkg::EXP_ADDR_ASYM_PAUSE) begin
				asym_pause_cfg <= reg_wdata_in[0];
			end
			if (data_write && expanded_address_pointer == mgmt_regs_pkg::EXP_ADDR_NP_NOTICE
				&& reg_wdata_in == mgmt_regs_pkg::EXP_NP_NOTICE_VALUE) begin
				np_loaded <= 1'b1;
			end else if (page_tx_valid_out) begin
				np_loaded <= 1'b0;
			end
		end
	end

	// Receive page register; a new page wins over a same-cycle clear
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			next_page_receive <= 16'h0000;
		end else if (page_rx_valid_in && neg_state == mgmt_regs_pkg::NEG_WAIT) begin
			next_page_receive <= page_rx_data_in;
		end else if (reg_wr_in && hit(reg_addr_in, mgmt_regs_pkg::REG_NEXT_PAGE_RECEIVE)) begin
			next_page_receive <= reg_wdata_in;
		end
	end

	// Isolate timer: reload on reset or isolate clear, count down to normal
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			isolate_out <= 1'b1;
			iso_timer <= mgmt_regs_pkg::TIMER_BITS'(mgmt_regs_pkg::RESET_RELEASE_CYCLES - 1);
		end else if (reg_wr_in && hit(reg_addr_in, mgmt_regs_pkg::REG_BASIC_CONTROL)) begin
			if (reg_wdata_in[mgmt_regs_pkg::BC_SOFT_RESET_BIT]) begin
				isolate_out <= 1'b1;
				iso_timer <= mgmt_regs_pkg::TIMER_BITS'(mgmt_regs_pkg::RESET_RELEASE_CYCLES - 1);
			end else if (reg_wdata_in[mgmt_regs_pkg::BC_ISOLATE_BIT]) begin
				isolate_out <= 1'b1;
			end else if (basic_control[mgmt_regs_pkg::BC_ISOLATE_BIT]) begin
				iso_timer <= mgmt_regs_pkg::TIMER_BITS'(mgmt_regs_pkg::ISOLATE_CLEAR_CYCLES - 1);
			end
		end else if (isolate_out && !basic_control[mgmt_regs_pkg::BC_ISOLATE_BIT]) begin
			if (iso_timer == '0) begin
				isolate_out <= 1'b0;
			end else begin
				iso_timer <= iso_timer - 1'b1;
			end
		end
	end

	// Next-page exchange: the device stops after its own last page rather
	// than sending a closing page, so a partner page asking for more sets neg_failed_out at once
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			neg_state <= mgmt_regs_pkg::NEG_IDLE;
			page_tx_valid_out <= 1'b0;
			page_tx_data_out <= 16'h0000;
			neg_complete_out <= 1'b0;
			neg_failed_out <= 1'b0;
		end else begin
			page_tx_valid_out <= 1'b0;
			if (restart_req) begin
				neg_state <= mgmt_regs_pkg::NEG_SEND;
				neg_complete_out <= 1'b0;
				neg_failed_out <= 1'b0;
			end else begin
				unique case (neg_state)
					mgmt_regs_pkg::NEG_IDLE: begin
					end
					mgmt_regs_pkg::NEG_SEND: begin
						if (np_loaded) begin
							page_tx_valid_out <= 1'b1;
							page_tx_data_out <= next_page_transmit;
							neg_state <= mgmt_regs_pkg::NEG_WAIT;
						end
					end
					mgmt_regs_pkg::NEG_WAIT: begin
						if (page_rx_valid_in) begin
							if (!page_tx_data_out[mgmt_regs_pkg::NEXT_PAGE_FOLLOWS_FLAG_BIT]) begin
								neg_state <= mgmt_regs_pkg::NEG_DONE;
								// Partner wanting more gets no closing page
								neg_failed_out <=
									page_rx_data_in[mgmt_regs_pkg::NEXT_PAGE_FOLLOWS_FLAG_BIT];
								neg_complete_out <=
									!page_rx_data_in[mgmt_regs_pkg::NEXT_PAGE_FOLLOWS_FLAG_BIT];
							end else begin
								neg_state <= mgmt_regs_pkg::NEG_SEND;
							end
						end
					end
					mgmt_regs_pkg::NEG_DONE: begin
					end
				endcase
			end
		end
	end

	// Read multiplexer; the data window returns the pre-increment location
	always_comb begin
		unique case (reg_addr_in)
			mgmt_regs_pkg::REG_BASIC_CONTROL: next_rdata = basic_control;
			mgmt_regs_pkg::REG_AUTONEG_ADVERTISEMENT: next_rdata = advertisement;
			mgmt_regs_pkg::REG_NEXT_PAGE_TRANSMIT: next_rdata = next_page_transmit;
			mgmt_regs_pkg::REG_NEXT_PAGE_RECEIVE: next_rdata = next_page_receive;
			mgmt_regs_pkg::REG_EXPANDED_ACCESS_ENABLE: next_rdata = expanded_access_enable;
			mgmt_regs_pkg::REG_EXPANDED_DATA_WINDOW:
				next_rdata = window_open ? {8'h00, mem_if.rd_data} : 16'h0000;
			mgmt_regs_pkg::REG_EXPANDED_ADDRESS_POINTER: next_rdata = expanded_address_pointer;
			default: next_rdata = 16'h0000;
		endcase
	end

	// Registered read data, held until the next read
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			reg_rdata_out <= 16'h0000;
		end else if (reg_rd_in) begin
			reg_rdata_out <= next_rdata;
		end
	end

	// Pause advertisement comes only through the expanded location
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			asym_pause_adv_out <= 1'b0;
		end else begin
			asym_pause_adv_out <= asym_pause_cfg;
		end
	end
endmodule // phy_expanded_access_next_page
`default_nettype wire

// [tb/mgmt_station_model.sv]
// Station management controller model that issues register cycles
`default_nettype none
module mgmt_station_model (
	input wire logic core_clk_in, // Clock
	input wire logic [15:0] reg_rdata_in, // Read data
	output var logic reg_wr_out, // Write
	output var logic reg_rd_out, // Read
	output var logic [4:0] reg_addr_out, // Address
	output var logic [15:0] reg_wdata_out // Write data
);
	timeunit 1ns;
	timeprecision 100ps;
	// Idle bus at time zero
	initial begin
		reg_wr_out = 1'b0;
		reg_rd_out = 1'b0;
		reg_addr_out = 5'h00;
		reg_wdata_out = 16'h0000;
	end
	// Data turns to its inverse once taken, so stale data never looks valid
	task automatic wr(input logic [4:0] a, input logic [15:0] d);
		@(posedge core_clk_in);
		reg_wr_out <= 1'b1;
		reg_addr_out <= a;
		reg_wdata_out <= d;
		@(posedge core_clk_in);
		reg_wr_out <= 1'b0;
		reg_wdata_out <= ~d;
	endtask
	// Answer is held, so it is picked up one edge after the strobe ends
	task automatic rd(input logic [4:0] a, output logic [15:0] d);
		@(posedge core_clk_in);
		reg_rd_out <= 1'b1;
		reg_addr_out <= a;
		@(posedge core_clk_in);
		reg_rd_out <= 1'b0;
		@(posedge core_clk_in);
		#1 d = reg_rdata_in;
	endtask
	// Order matters: key, pointer, then data
	task automatic asym_pause_advertise();
		wr(5'h16, mgmt_regs_pkg::EXPANDED_ENABLE_KEY);
		wr(5'h1E, mgmt_regs_pkg::EXP_ADDR_ASYM_PAUSE);
		wr(5'h1D, 16'h0001);
	endtask
	// Whole transmit word, then the loaded-page notice
	task automatic np_load(input logic [15:0] page);
		wr(5'h07, page);
		wr(5'h16, mgmt_regs_pkg::EXPANDED_ENABLE_KEY);
		wr(5'h1E, mgmt_regs_pkg::EXP_ADDR_NP_NOTICE);
		wr(5'h1D, mgmt_regs_pkg::EXP_NP_NOTICE_VALUE);
	endtask
endmodule // mgmt_station_model
`default_nettype wire

// [tb/phy_expanded_access_next_page_properties.sv]
// Port assertions for the management register bank
`default_nettype none
module phy_expanded_access_next_page_properties (
	input wire logic core_clk_in, // Clock
	input wire logic rstn_in, // Reset
	input wire logic reg_wr_in, // Write
	input wire logic reg_rd_in, // Read
	input wire logic [4:0] reg_addr_in, // Address
	input wire logic [15:0] reg_wdata_in, // Data in
	input wire logic page_rx_valid_in, // Rx page
	input wire logic [15:0] page_rx_data_in, // Rx word
	input wire logic [15:0] reg_rdata_out, // Data out
	input wire logic isolate_out, // Isolate
	input wire logic page_tx_valid_out, // Tx page
	input wire logic [15:0] page_tx_data_out, // Tx word
	input wire logic neg_complete_out, // Done
	input wire logic neg_failed_out, // Failed
	input wire logic asym_pause_adv_out // Advert
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge core_clk_in); endclocking
	default disable iff (!rstn_in);
	logic key, rel, arm, iso_bit, pend;
	logic [15:0] ptr, np_tx;
	logic [16:0] cnt;
	logic [1:0] rx_end, rx_more;
	wire logic hit = (reg_wr_in || reg_rd_in) && reg_addr_in == 5'h1D && key;
	wire logic notice = hit && reg_wr_in && ptr == 16'h80DD && reg_wdata_in == 16'h0040;
	wire logic pause_wr = hit && reg_wr_in && ptr == 16'h8084 && reg_wdata_in[0];
	// Shadow state; a slow isolate release shows up as a long count
	always_ff @(posedge core_clk_in) begin
		if (!rstn_in) begin
			key <= 1'b0;
			ptr <= 16'h0000;
			np_tx <= 16'h0000;
			rel <= 1'b1;
			arm <= 1'b1;
			cnt <= 17'h00000;
			rx_end <= 2'b00;
			rx_more <= 2'b00;
			iso_bit <= 1'b0;
			pend <= 1'b0;
		end else begin
			if (reg_wr_in && reg_addr_in == 5'h16) key <= reg_wdata_in == 16'h000D;
			if (reg_wr_in && reg_addr_in == 5'h1E) ptr <= reg_wdata_in;
			else if (hit) ptr <= ptr + 16'h0001;
			if (reg_wr_in && reg_addr_in == 5'h07) np_tx <= reg_wdata_in;
			rx_end <= {rx_end[0], page_rx_valid_in && !page_rx_data_in[15]};
			rx_more <= {rx_more[0], page_rx_valid_in && page_rx_data_in[15]};
			cnt <= isolate_out ? cnt + 17'h00001 : 17'h00000;
			if (!isolate_out) begin
				rel <= 1'b0;
				arm <= 1'b0;
			end
			// A notice may come long before the restart, so it is remembered
			if (notice) pend <= 1'b1;
			else if (page_tx_valid_out) pend <= 1'b0;
			// Isolate clear reloads the short count; soft reset the long one
			if (reg_wr_in && reg_addr_in == 5'h00) begin
				iso_bit <= reg_wdata_in[10] && !reg_wdata_in[15];
				if (reg_wdata_in[15]) begin
					rel <= 1'b1;
					arm <= 1'b1;
					cnt <= 17'h00000;
				end else if (!reg_wdata_in[10] && iso_bit) begin
					rel <= 1'b0;
					arm <= 1'b1;
					cnt <= 17'h00000;
				end
			end
		end
	end
	property p_iso_time; arm |-> cnt <= (rel ? mgmt_regs_pkg::RESET_RELEASE_CYCLES :
		mgmt_regs_pkg::ISOLATE_CLEAR_CYCLES) + 3; endproperty
	a_iso_time: assert property (p_iso_time) else $error("isolate held too long");
	property p_reset_iso; $rose(rstn_in) |-> isolate_out && !neg_complete_out; endproperty
	a_reset_iso: assert property (p_reset_iso) else $error("not isolated after reset");
	property p_adv_bit; reg_rd_in && reg_addr_in == 5'h04 |-> ##2 !reg_rdata_out[11]; endproperty
	a_adv_bit: assert property (p_adv_bit) else $error("pause bit reads one");
	property p_shut; reg_rd_in && reg_addr_in == 5'h1D && !key |-> ##2 reg_rdata_out == 0; endproperty
	a_shut: assert property (p_shut) else $error("closed window read nonzero");
	property p_ptr; reg_rd_in && reg_addr_in == 5'h1E |-> ##2 reg_rdata_out == $past(ptr, 2); endproperty
	a_ptr: assert property (p_ptr) else $error("pointer value wrong");
	property p_adv_src; $rose(asym_pause_adv_out) |-> $past(pause_wr, 2); endproperty
	a_adv_src: assert property (p_adv_src) else $error("advert without window write");
	property p_tx_cause; page_tx_valid_out |-> pend; endproperty
	a_tx_cause: assert property (p_tx_cause) else $error("page sent without notice");
	property p_tx_word; page_tx_valid_out |-> page_tx_data_out == np_tx ##1 !page_tx_valid_out;
	endproperty
	a_tx_word: assert property (p_tx_word) else $error("sent page word wrong");
	property p_done; $rose(neg_complete_out) |-> rx_end != 2'b00; endproperty
	a_done: assert property (p_done) else $error("completion without final page");
	property p_fail; $rose(neg_failed_out) |-> rx_more != 2'b00; endproperty
	a_fail: assert property (p_fail) else $error("failure without more pages");
endmodule // phy_expanded_access_next_page_properties
bind phy_expanded_access_next_page phy_expanded_access_next_page_properties chk_u (
	.core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_wr_in(reg_wr_in), .reg_rd_in(reg_rd_in),
	.reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in), .page_rx_valid_in(page_rx_valid_in),
	.page_rx_data_in(page_rx_data_in), .reg_rdata_out(reg_rdata_out), .isolate_out(isolate_out),
	.page_tx_valid_out(page_tx_valid_out), .page_tx_data_out(page_tx_data_out),
	.neg_complete_out(neg_complete_out), .neg_failed_out(neg_failed_out),
	.asym_pause_adv_out(asym_pause_adv_out));
`default_nettype wire

// [tb/phy_expanded_access_next_page_tb.sv]
// Self-checking bench for the management register bank
`default_nettype none
module phy_expanded_access_next_page_tb;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct {logic [15:0] exp; logic [15:0] mask;} note_s;
	note_s rq[$];
	note_s n;
	logic [15:0] pq[$];
	logic core_clk_in = 1'b0;
	logic rstn_in = 1'b0;
	logic rx_v = 1'b0;
	logic [15:0] rx_w = 16'h0000, idle = 16'h5A5A, v, p;
	logic [31:0] seed = 32'h06d9c072;
	logic [1:0] rd_pipe = 2'b00;
	logic [7:0] dd [3];
	logic [4:0] ra [8] = '{5'h00, 5'h04, 5'h07, 5'h08, 5'h16, 5'h1D, 5'h1E, 5'h05};
	logic [15:0] rv [8] = '{16'h1000, 16'h01E1, 0, 0, 0, 0, 0, 0};
	int err_count = 0, checked = 0, cycles = 0;
	wire logic wr, rd, iso, tx_v, ok, bad, adv;
	wire logic [4:0] addr;
	wire logic [15:0] wdata, rdata, tx_d;
	wire logic [15:0] rx_d = rx_v ? rx_w : idle;
	always #5 core_clk_in = ~core_clk_in;
	phy_expanded_access_next_page dut_u (.core_clk_in(core_clk_in), .rstn_in(rstn_in),
		.reg_wr_in(wr), .reg_rd_in(rd), .reg_addr_in(addr), .reg_wdata_in(wdata),
		.page_rx_valid_in(rx_v), .page_rx_data_in(rx_d), .reg_rdata_out(rdata),
		.isolate_out(iso), .page_tx_valid_out(tx_v), .page_tx_data_out(tx_d),
		.neg_complete_out(ok), .neg_failed_out(bad), .asym_pause_adv_out(adv));
	mgmt_station_model mgmt_u (.core_clk_in(core_clk_in), .reg_rdata_in(rdata),
		.reg_wr_out(wr), .reg_rd_out(rd), .reg_addr_out(addr), .reg_wdata_out(wdata));
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic rdq(input logic [4:0] a, input logic [15:0] e, input logic [15:0] m);
		rq.push_back('{e, m});
		mgmt_u.rd(a, v);
	endtask
	task automatic start_reset();
		rstn_in <= 1'b0;
		repeat (10) @(posedge core_clk_in);
		rstn_in <= 1'b1;
	endtask
	// Isolate must fall near the fixed release count, neither early nor late
	task automatic wait_iso(input int lim);
		int k;
		k = 0;
		while (iso !== 1'b0 && k < lim + 10) begin
			@(posedge core_clk_in);
			k++;
		end
		chk("isolate release", {15'h0000, k <= lim + 3 && k > lim - 10}, 16'h0001);
	endtask
	// One page each way, then poll the receive register
	task automatic np_round(input logic [15:0] own, input logic [15:0] lp);
		mgmt_u.wr(5'h08, 16'h0000);
		rdq(5'h08, 16'h0000, 16'hFFFF);
		pq.push_back(own);
		mgmt_u.np_load(own);
		for (int k = 0; k < 20 && pq.size() > 0; k++) @(posedge core_clk_in);
		chk("page sent", 16'(pq.size()), 16'h0000);
		pq.delete();
		rx_v <= 1'b1;
		rx_w <= lp;
		@(posedge core_clk_in);
		rx_v <= 1'b0;
		// Stands in for the seconds-long settling before polling, scaled down
		repeat (4) @(posedge core_clk_in);
		v = 16'h0000;
		for (int k = 0; k < 8 && v == 16'h0000; k++) rdq(5'h08, 16'h0000, 16'h0000);
		chk("received page", v, lp);
	endtask
	// Changing word on the page lines while no page is offered
	always @(posedge core_clk_in) idle <= ~idle + 16'h1357;
	// Each read answer against the oldest note
	always @(posedge core_clk_in) begin
		rd_pipe <= {rd_pipe[0], rd === 1'b1};
		if (rd_pipe[1] && rq.size() > 0) begin
			n = rq.pop_front();
			chk("read data", rdata & n.mask, n.exp & n.mask);
		end
		if (tx_v === 1'b1) chk("page word", tx_d, pq.size() > 0 ? pq.pop_front() : 16'hXXXX);
	end
	// Ceiling: one reset release and two isolate clears, with margin
	always @(posedge core_clk_in) begin
		cycles++;
		if (cycles > 80000) begin
			err_count++;
			finish_test();
		end
	end
	initial begin
		start_reset();
		wait_iso(mgmt_regs_pkg::RESET_RELEASE_CYCLES);
		foreach (ra[i]) rdq(ra[i], rv[i], 16'hFFFF);
		mgmt_u.wr(5'h04, 16'hFFFF);
		rdq(5'h04, 16'h0000, 16'h0800);
		$display("test reset values done");
		mgmt_u.wr(5'h1D, 16'h00AA);
		rdq(5'h1E, 16'h0000, 16'hFFFF);
		mgmt_u.wr(5'h16, mgmt_regs_pkg::EXPANDED_ENABLE_KEY);
		void'(rnd());
		p = {seed[23:16], 8'h20};
		foreach (dd[i]) dd[i] = 8'(rnd());
		mgmt_u.wr(5'h1E, p);
		foreach (dd[i]) mgmt_u.wr(5'h1D, {seed[15:8], dd[i]});
		rdq(5'h1E, p + 16'h0003, 16'hFFFF);
		mgmt_u.wr(5'h1E, p);
		foreach (dd[i]) rdq(5'h1D, {8'h00, dd[i]}, 16'hFFFF);
		rdq(5'h1E, p + 16'h0003, 16'hFFFF);
		mgmt_u.asym_pause_advertise();
		repeat (3) @(posedge core_clk_in);
		chk("pause advert", {15'h0000, adv}, 16'h0001);
		mgmt_u.wr(5'h1E, mgmt_regs_pkg::EXP_ADDR_ASYM_PAUSE);
		rdq(5'h1D, 16'h0001, 16'hFFFF);
		$display("test expanded window done");
		mgmt_u.wr(5'h00, 16'h1400);
		@(posedge core_clk_in);
		#1 chk("isolate set", {15'h0000, iso}, 16'h0001);
		mgmt_u.wr(5'h00, 16'h1000);
		wait_iso(mgmt_regs_pkg::ISOLATE_CLEAR_CYCLES);
		$display("test isolate done");
		for (int r = 0; r < 2; r++) begin
			if (r == 1) begin
				start_reset();
				@(posedge core_clk_in);
				#1 chk("isolate after reset", {15'h0000, iso}, 16'h0001);
				// Set and clear isolate so the short count replaces the long one
				mgmt_u.wr(5'h00, 16'h1400);
				mgmt_u.wr(5'h00, 16'h1000);
				wait_iso(mgmt_regs_pkg::ISOLATE_CLEAR_CYCLES);
			end
			mgmt_u.wr(5'h00, 16'h0000);
			mgmt_u.wr(5'h04, 16'h81E1);
			mgmt_u.wr(5'h08, 16'h0000);
			mgmt_u.wr(5'h00, 16'h1200);
			if (r == 0) np_round(16'h8123, 16'h8456);
			np_round(16'h0124, r == 0 ? 16'h0457 : 16'h8457);
			repeat (3) @(posedge core_clk_in);
			chk("outcome", {14'h0000, ok, bad}, r == 0 ? 16'h0002 : 16'h0001);
			$display("test next page pass %0d done", r);
		end
		finish_test();
	end
endmodule // phy_expanded_access_next_page_tb
`default_nettype wire
